// [rtl/pcd_port_map.vh]
// pcd_port_map.vh: register offsets, reset values and field positions
// assumes: included by the port block only; offsets are from the io block base
`ifndef PCD_PORT_MAP_VH
`define PCD_PORT_MAP_VH

// register index within one port (offset = port base + index)
`define PCD_REG_INPUT      4'h0
`define PCD_REG_OUTPUT     4'h1
`define PCD_REG_CELLOUT    4'h2
`define PCD_REG_LOADBLK    4'h3
`define PCD_REG_CELLIN     4'h4
`define PCD_REG_DRVEN      4'h5
`define PCD_REG_MODE       4'h6
`define PCD_REG_DIR        4'h7
`define PCD_REG_DRIVE      4'h8
// port field in the offset
`define PCD_PORT_MSB       5
`define PCD_PORT_LSB       4
`define PCD_PORT_A         2'h0
`define PCD_PORT_B         2'h1
`define PCD_PORT_C         2'h2
`define PCD_PORT_D         2'h3
// reset values
`define PCD_SETUP_RST      8'h00
`define PCD_LOADBLK_RST    8'h00
`define PCD_CELL_RST       8'h00
`define PCD_OUTPUT_RST     8'h00
// port d implements three pins
`define PCD_PORTD_MASK     8'h07
// drive select field split on ports a and b
`define PCD_AB_OPEN_MASK   8'hF0
`define PCD_AB_SLEW_MASK   8'h0F

`endif

// [rtl/pcd_port.v]
// pcd_port.v: configuration and data registers of four i/o ports
// assumes: host bus sampled on sys_clk, one-cycle wrEn/rdEn strobes decoded
// from the io block select; logic-array terms arrive synchronous to sys_clk
//
// Summary of operation
// - register bit n governs pin n only
// - mode, direction, drive registers reset to zero
// - mode bit 0 port io, 1 address out
// - mode register only on ports a, b
// - direction 1 output, 0 input; default input
// - output when direction or logic enable set; port d on direction only
// - port d direction has three bits only
// - drive bit 1 open drain, else push-pull
// - drive bit 1 fast slew, else slow
// - drive bit meaning differs per port
// - input register reads live pin levels
// - output register read back, drives enabled pins
// - cell write loads unmasked flip-flops, read returns
// - load-block bit 1 prevents host loading of that output cell, which holds during a host cell write; the array result loads on all other clocks
// - input cells latch pins, readable by host
// - enable register shows each driver enable; port d reads zero
// - cell registers only on ports a, b, c
// - host reaches registers by plain bus cycles
// - port c pins shared with scan programming
`timescale 1ns/1ps
`include "pcd_port_map.vh"

module pcd_port #(
   parameter NPORT = 4
) (
   // clock and reset
   input  wire         sys_clk,
   input  wire         nrst,
   // host register bus
   input  wire [5:0]   regAddr,
   input  wire [7:0]   wrData,
   input  wire         wrEn,
   input  wire         rdEn,
   output reg  [7:0]   rdData,
   // logic array side, per-port buses packed 8 bits each (a..d, cell buses a..c)
   input  wire [31:0]  arrayOe,
   input  wire [31:0]  arrayOut,
   input  wire [23:0]  cellInLoad,
   input  wire [15:0]  latchedAddr,
   input  wire         scanActive,
   input  wire [7:0]   scanOut,
   input  wire [7:0]   scanOe,
   output wire [23:0]  cellOut,
   output wire [23:0]  cellIn,
   // pins, four signals each
   input  wire [31:0]  pinIn,
   output wire [31:0]  pinOut,
   output wire [31:0]  pinOe,
   output wire [31:0]  fastSlew
);

   ////////////////////////////////////////////////////////////////////////////
   // register decode
   wire [1:0] selPort = regAddr[`PCD_PORT_MSB:`PCD_PORT_LSB];
   wire [3:0] selReg  = regAddr[3:0];

   // storage per port
   reg  [7:0] modeQ   [0:NPORT-1];
   reg  [7:0] dirQ    [0:NPORT-1];
   reg  [7:0] driveQ  [0:NPORT-1];
   reg  [7:0] outQ    [0:NPORT-1];
   reg  [7:0] cellQ   [0:NPORT-1];
   reg  [7:0] blockQ  [0:NPORT-1];
   reg  [7:0] cinQ    [0:NPORT-1];
   wire [7:0] enable  [0:NPORT-1];

   genvar p;
   generate
      for (p = 0; p < NPORT; p = p + 1) begin : gPort
         // which registers this port has
         localparam HAS_MODE = (p < 2);
         localparam HAS_CELL = (p < 3);
         localparam [7:0] PMASK = (p == 3) ? `PCD_PORTD_MASK : 8'hFF;
         wire hit = wrEn && (selPort == p);
         wire [7:0] oeTerm = arrayOe[p*8 +: 8];
         wire [7:0] aOut;
         wire [7:0] dOut;
         wire [7:0] openDrain;
         wire [7:0] scanEn;

         // setup and data registers, written at end of host write
         always @(posedge sys_clk) begin
            if (!nrst) begin
               modeQ[p]  <= `PCD_SETUP_RST;
               dirQ[p]   <= `PCD_SETUP_RST;
               driveQ[p] <= `PCD_SETUP_RST;
               outQ[p]   <= `PCD_OUTPUT_RST;
               blockQ[p] <= `PCD_LOADBLK_RST;
            end else if (hit) begin
               if (selReg == `PCD_REG_MODE && HAS_MODE)
                  modeQ[p] <= wrData;
               if (selReg == `PCD_REG_DIR)
                  dirQ[p] <= wrData & PMASK;
               if (selReg == `PCD_REG_DRIVE)
                  driveQ[p] <= wrData & PMASK;
               if (selReg == `PCD_REG_OUTPUT)
                  outQ[p] <= wrData & PMASK;
               if (selReg == `PCD_REG_LOADBLK && HAS_CELL)
                  blockQ[p] <= wrData;
            end
         end

         // output cells: array result each clock but a host cell write, which loads unblocked bits and holds blocked ones
         always @(posedge sys_clk) begin
            if (!nrst)
               cellQ[p] <= `PCD_CELL_RST;
            else if (!HAS_CELL)
               cellQ[p] <= `PCD_CELL_RST;
            else if (hit && selReg == `PCD_REG_CELLOUT)
               cellQ[p] <= (wrData & ~blockQ[p]) | (cellQ[p] & blockQ[p]);
            else
               cellQ[p] <= arrayOut[p*8 +: 8];
         end

         // input cells latch pins on their load strobe
         always @(posedge sys_clk) begin
            if (!nrst)
               cinQ[p] <= `PCD_CELL_RST;
            else if (HAS_CELL)
               cinQ[p] <= (pinIn[p*8 +: 8] & cellInLoad[p*8 +: 8])
                        | (cinQ[p] & ~cellInLoad[p*8 +: 8]);
         end

         // pin drive: address out when mode bit set, else data register
         assign aOut = (p == 0) ? latchedAddr[7:0] : latchedAddr[15:8];
         assign dOut = HAS_MODE ? ((modeQ[p] & aOut) | (~modeQ[p] & outQ[p]))
                                : outQ[p];
         assign enable[p] = ((p == 3) ? dirQ[p] : (dirQ[p] | oeTerm)) & PMASK;
         // open drain only releases the high level
         assign openDrain = (p == 3) ? 8'h00 :
                            (p == 2) ? driveQ[p] : (driveQ[p] & `PCD_AB_OPEN_MASK);
         assign fastSlew[p*8 +: 8] = (p == 2) ? 8'h00 :
                            (p == 3) ? driveQ[p] : (driveQ[p] & `PCD_AB_SLEW_MASK);
         // scan programming overrides the port c pins selected by scanOe while active
         assign scanEn = (p == 2 && scanActive) ? scanOe : 8'h00;
         assign pinOut[p*8 +: 8] = (scanEn & scanOut) | (~scanEn & dOut);
         assign pinOe[p*8 +: 8]  = scanEn |
                            (enable[p] & ~(openDrain & dOut));
      end
   endgenerate

   // cell outputs exist for ports a..c only, one driver per slice
   assign cellOut = {cellQ[2], cellQ[1], cellQ[0]};
   assign cellIn  = {cinQ[2], cinQ[1], cinQ[0]};

   ////////////////////////////////////////////////////////////////////////////
   // read mux, registered; reads change no state
   reg [7:0] rdMux;
   always @* begin
      rdMux = 8'h00;
      case (selReg)
         `PCD_REG_INPUT:   rdMux = pinIn[selPort*8 +: 8]
                                   & ((selPort == `PCD_PORT_D) ? `PCD_PORTD_MASK : 8'hFF);
         `PCD_REG_OUTPUT:  rdMux = outQ[selPort];
         `PCD_REG_CELLOUT: rdMux = cellQ[selPort];
         `PCD_REG_LOADBLK: rdMux = blockQ[selPort];
         `PCD_REG_CELLIN:  rdMux = cinQ[selPort];
         `PCD_REG_DRVEN:   rdMux = (selPort == `PCD_PORT_D) ? 8'h00 : enable[selPort];
         `PCD_REG_MODE:    rdMux = modeQ[selPort];
         `PCD_REG_DIR:     rdMux = dirQ[selPort];
         `PCD_REG_DRIVE:   rdMux = driveQ[selPort];
         default:          rdMux = 8'h00;
      endcase
   end

   always @(posedge sys_clk) begin
      if (!nrst)
         rdData <= 8'h00;
      else if (rdEn)
         rdData <= rdMux;
   end

endmodule // pcd_port

// [tb/pcd_pin_model.sv]
// pcd_pin_model.sv: board side of the port pins, one pull-up per pin
// assumes: pinOe high while the block drives; a released pin floats high
`timescale 1ns/1ps
module pcd_pin_model (
   // pin side of the block
   input  wire logic [31:0] pinOut,
   input  wire logic [31:0] pinOe,
   output wire logic [31:0] pinIn
);
   // a driven pin shows its value, a released one the pull-up
   assign pinIn = pinOut | ~pinOe;
endmodule // pcd_pin_model

// [tb/pcd_port_monitor.sv]
// pcd_port_monitor.sv: concurrent checks on the port block ports
// assumes: bound to pcd_port, one sys_clk domain
`timescale 1ns/1ps
module pcd_port_monitor (
   // clock, reset and host bus
   input wire        sys_clk, nrst, wrEn, rdEn,
   input wire [5:0]  regAddr,
   input wire [7:0]  wrData, rdData,
   // array and pin side
   input wire [31:0] arrayOe, pinIn, pinOe, fastSlew,
   input wire [23:0] cellInLoad, cellIn
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////////
   hold_rd_a: assert property (!rdEn |=> $stable(rdData))
      else $error("read data moved without a read");
   rst_zero_a: assert property ($rose(nrst) |-> rdData == 8'h00)
      else $error("read data not clear after reset");
   rd_pin_a: assert property (rdEn && regAddr == 6'h00 |=> rdData == $past(pinIn[7:0]))
      else $error("input read not pin level");
   rd_oe_a: assert property (rdEn && regAddr == 6'h05 |=> rdData == $past(pinOe[7:0]))
      else $error("enable read not driver state");
   rd_gap_a: assert property (rdEn && (regAddr[3:0] > 4'h8 || regAddr == 6'h35)
      |=> rdData == 8'h00)
      else $error("absent register not zero");
   dir_wr_a: assert property (wrEn && regAddr == 6'h07
      |=> pinOe[3:0] == ($past(wrData[3:0]) | arrayOe[3:0]))
      else $error("direction write not on pins");
   oe_or_a: assert property ((arrayOe[3:0] & ~pinOe[3:0]) == 4'h0)
      else $error("array enable ignored");
   d_pins_a: assert property (pinOe[31:27] == 5'h00)
      else $error("absent port d pin driven");
   slew_map_a: assert property ({fastSlew[31:27], fastSlew[23:16], fastSlew[15:12],
      fastSlew[7:4]} == 21'h000000)
      else $error("slew on open drain pin");
   cell_in_a: assert property (cellInLoad[7:0] == 8'hFF |=> cellIn[7:0] == $past(pinIn[7:0]))
      else $error("input cell missed pins");
   // main scenarios reached
   cover property (wrEn && regAddr == 6'h07);
   cover property (rdEn && regAddr == 6'h05);
   cover property (cellInLoad[7:0] == 8'hFF);
endmodule // pcd_port_monitor
bind pcd_port pcd_port_monitor mon (.sys_clk, .nrst, .wrEn, .rdEn, .regAddr, .wrData,
   .rdData, .arrayOe, .pinIn, .pinOe, .fastSlew, .cellInLoad, .cellIn);

// [tb/pcd_port_tb.sv]
// pcd_port_tb.sv: directed tests of the port register block
// assumes: pcd_port and pin model compiled first; 40 MHz sys_clk
`timescale 1ns/1ps
module pcd_port_tb;
   logic        sys_clk = 0, nrst = 0, wrEn = 0, rdEn = 0, scanActive = 0;
   logic [5:0]  regAddr = 6'h00;
   logic [7:0]  wrData = 8'h00, scanOut = 8'h00, scanOe = 8'h00;
   logic [31:0] arrayOe = 32'h0, arrayOut = 32'h0;
   logic [23:0] cellInLoad = 24'h0;
   logic [15:0] latchedAddr = 16'h0;
   wire  [7:0]  rdData;
   wire  [31:0] pinIn, pinOut, pinOe, fastSlew;
   wire  [23:0] cellOut, cellIn;
   int          miscompares = 0, total_checks = 0;
   pcd_port #(.NPORT(4)) DUT (.sys_clk, .nrst, .regAddr, .wrData, .wrEn, .rdEn, .rdData,
      .arrayOe, .arrayOut, .cellInLoad, .latchedAddr, .scanActive, .scanOut, .scanOe,
      .cellOut, .cellIn, .pinIn, .pinOut, .pinOe, .fastSlew);
   pcd_pin_model pins (.pinOut, .pinOe, .pinIn);
   initial forever #12.5 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %0t got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge sys_clk) {regAddr, wrData, wrEn} = {a, d, 1'b1};
      @(negedge sys_clk) wrEn = 0;
   endtask
   task rd(input logic [5:0] a, input logic [7:0] exp);
      @(negedge sys_clk) {regAddr, rdEn} = {a, 1'b1};
      @(negedge sys_clk) rdEn = 0;
      chk(rdData, exp);
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task t_reset;
      for (int i = 0; i < 12; i++) rd(6'((i / 3) * 16 + 6 + i % 3), 8'h00);
      $display("test reset done");
   endtask
   task t_dir;
      wr(6'h07, 8'h07);
      chk(pinOe[7:0], 8'h07);
      wr(6'h37, 8'hFF);
      rd(6'h37, 8'h07);
      wr(6'h26, 8'hFF);
      rd(6'h26, 8'h00);
      rd(6'h0F, 8'h00);
      rd(6'h35, 8'h00);
      arrayOe = 32'h30;
      rd(6'h05, 8'h37);
      arrayOe = 32'h0;
      $display("test direction done");
   endtask
   task t_out;
      wr(6'h01, 8'h5A);
      wr(6'h07, 8'hFF);
      rd(6'h01, 8'h5A);
      chk(pinOut[7:0], 8'h5A);
      wr(6'h08, 8'hFF);
      chk(pinOe[7:0], 8'hAF);
      chk(fastSlew[7:0], 8'h0F);
      rd(6'h00, 8'h5A);
      rd(6'h10, 8'hFF);
      $display("test output done");
   endtask
   task t_cell;
      wr(6'h03, 8'h0F);
      wr(6'h02, 8'hFF);
      chk(cellOut[7:0], 8'hF0);
      rd(6'h03, 8'h0F);
      cellInLoad = 24'hFF;
      @(negedge sys_clk) cellInLoad = 24'h0;
      rd(6'h04, 8'h5A);
      latchedAddr = 16'h00C3;
      wr(6'h06, 8'hFF);
      chk(pinOut[7:0], 8'hC3);
      $display("test cells done");
   endtask
   task t_scan;
      @(negedge sys_clk) {scanActive, scanOe, scanOut} = {1'b1, 8'hFF, 8'hA5};
      @(negedge sys_clk);
      chk(pinOut[23:16], 8'hA5);
      chk(pinOe[23:16], 8'hFF);
      @(negedge sys_clk) scanActive = 0;
      @(negedge sys_clk);
      chk(pinOe[23:16], 8'h00);
      $display("test scan done");
   endtask
   // main sequence after four reset cycles
   initial begin
      repeat (4) @(negedge sys_clk);
      nrst = 1;
      t_reset();
      t_dir();
      t_out();
      t_cell();
      t_scan();
      report_and_stop();
   end
   // watchdog against a hung run
   initial begin
      #100us;
      miscompares++;
      report_and_stop();
   end
endmodule // pcd_port_tb
